// >>> shared/ofc_regs.svh
// register offsets, field positions, reset values and octet constants of the overhead channel framer
// Overview of operation
// - plain path sends CRC then one fill octet
// - lowest path sends CRC, four indicators, fill
// - message path adds message octets after fill
// - lowest message path length is count plus six
// - every fill octet is sent as all ones
// - exactly four octets carry indicator bits
// - phase down, defects both ways, power up
// - payload indicators pass through unchanged
// - physical and convergence indicators are active low
// - unused indicator bits are sent as one
// - octets carry phase, defects, ones, payload flags
// - defect octet bits 7-5 flags, rest ones
// - payload octet: first flags high, second low
// - messages framed by flag, fields, FCS, flag
// - message octets only in selected message path
// - message body never exceeds 1028 octets
// - per-path position counter wraps at sequence end
// - indicators to lowest-delay path, ties lowest label
`ifndef OFC_REGS_SVH
`define OFC_REGS_SVH
`define OFC_CTRL_ADDR 8'h00
`define OFC_MSGC_ADDR 8'h04
`define OFC_DELAY_ADDR 8'h08
`define OFC_STAT_ADDR 8'h0c
`define OFC_CTRL_RUN 0
`define OFC_CTRL_DOWN 1
`define OFC_CTRL_MSEL 4
`define OFC_STAT_OVER 0
`define OFC_STAT_UNDER 1
`define OFC_STAT_LOW 4
`define OFC_STAT_AVAIL 6
`define OFC_STAT_STATE 8
`define OFC_CTRL_RESET 32'h0000_0000
`define OFC_SEQ_BASE 2
`define OFC_SEQ_LOW 6
`define OFC_IND_LAST 4
`define OFC_FILL 8'hff
`define OFC_FLAG 8'h7e
`define OFC_FRAME_MAX 11'h404
`endif

// >>> shared/ofc_pkg.sv
// types shared by the overhead channel framer
package ofc_pkg;
  typedef logic [7:0] ofc_octet_t;
  typedef enum logic [1:0] {
    fr_idle = 2'b00,
    fr_body = 2'b01,
    fr_drop = 2'b10
  } ofc_fr_state_e;
endpackage : ofc_pkg

// >>> shared/ofc_strm_if.sv
// valid/ready octet stream between the framer and its message fifo
`timescale 1ns/1ns
`default_nettype none
interface ofc_strm_if #(
  parameter int W = 9
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface : ofc_strm_if
`default_nettype wire

// >>> hw/ofc_seq_cnt.sv
// per-path overhead sequence position counter
`timescale 1ns/1ns
`default_nettype none
module ofc_seq_cnt #(
  parameter int CW = 12
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic run_i, // counting allowed
  input wire logic adv_i, // one sync octet sent
  input wire logic [CW-1:0] len_i, // sequence length
  output logic [CW-1:0] pos_o // current position
);
  if (CW < 4) begin : g_bad
    $error("ofc_seq_cnt: CW too small");
  end

  // held at zero until the link comes up, so the first octet is always a CRC
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pos_o <= '0;
    end else if (adv_i) begin
      pos_o <= (pos_o == len_i - CW'(1)) ? '0 : pos_o + CW'(1);
    end
  end

  chk_pos_wraps: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && adv_i && pos_o == len_i - CW'(1) |=> pos_o == '0)
    else $error("sequence position did not wrap");
  chk_pos_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && $stable(len_i) |-> pos_o < len_i)
    else $error("sequence position beyond length");
endmodule : ofc_seq_cnt
`default_nettype wire

// >>> hw/ofc_fifo.sv
// flip-flop message fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ofc_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  ofc_strm_if.cons wr_s, // filling side
  ofc_strm_if.prod rd_s // draining side
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad
    $error("ofc_fifo: depth must be a power of two");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign wr_s.ready = cnt != (AW + 1)'(D);
  assign rd_s.valid = cnt != '0;
  assign rd_s.data = mem[rp];
  assign push = wr_s.valid && wr_s.ready;
  assign pop = rd_s.valid && rd_s.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= wr_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + AW'(1);
      end
      if (pop) begin
        rp <= rp + AW'(1);
      end
      cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  chk_fifo_fill: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt <= (AW + 1)'(D))
    else $error("fifo count beyond depth");
endmodule : ofc_fifo
`default_nettype wire

// >>> hw/ofc_framer.sv
// overhead channel framer: per-path sync octet sequencing and message framing
`timescale 1ns/1ns
`default_nettype none
`include "ofc_regs.svh"
module ofc_framer
  import ofc_pkg::*;
#(
  parameter int NPATH = 4, // latency paths
  parameter int CW = 12, // sequence counter width
  parameter int FDEPTH = 16 // message fifo depth
) (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // register write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  input wire logic [NPATH-1:0] sync_req_i, // sync octet slot per path
  input wire logic [NPATH*8-1:0] crc_octet_i, // CRC octet per path
  output logic [NPATH-1:0] ovh_valid_o, // overhead octet valid
  output logic [NPATH*8-1:0] ovh_octet_o, // overhead octet per path
  input wire logic [7:0] timing_phase_i, // phase change, downstream
  input wire logic signal_loss_flag_n_i, // loss of signal, low
  input wire logic remote_defect_flag_n_i, // remote defect, low
  input wire logic power_loss_flag_n_i, // loss of power, low
  input wire logic [3:0] payload_indicator_a_i, // first flag, fn 0..3
  input wire logic [3:0] payload_indicator_b_i, // second flag, fn 0..3
  input wire logic msg_valid_i, // message octet offered
  output logic msg_ready_o, // message octet taken
  input wire logic [7:0] msg_data_i, // address..FCS octets
  input wire logic msg_last_i // last octet of a message
);
  if (NPATH < 1 || NPATH > 4) begin : g_bad
    $error("ofc_framer: one to four paths");
  end

  // register file
  logic run;
  logic down;
  logic [1:0] msel;
  logic [CW-1:0] msgc;
  logic [31:0] delay_r;
  logic over_f;
  logic under_f;
  logic set_over;
  logic set_under;

  // configuration frozen when the link comes up
  logic active;
  logic [1:0] low_q;
  logic [1:0] msg_q;
  logic [CW-1:0] msgc_q;
  logic [1:0] next_low;

  // message framing
  ofc_fr_state_e st;
  logic [10:0] fcnt;
  logic [NPATH-1:0] slot_w;
  logic slot;
  ofc_octet_t msg_oct;
  ofc_octet_t ind [1:`OFC_IND_LAST];

  ofc_strm_if #(.W(9)) in_q ();
  ofc_strm_if #(.W(9)) out_q ();

  wire wr_ctrl = wr_i && addr_i == `OFC_CTRL_ADDR;
  wire wr_stat = wr_i && addr_i == `OFC_STAT_ADDR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'(`OFC_CTRL_RESET);
      down <= 1'b0;
      msel <= 2'h0;
    end else if (wr_ctrl) begin
      run <= wdata_i[`OFC_CTRL_RUN];
      down <= wdata_i[`OFC_CTRL_DOWN];
      msel <= wdata_i[`OFC_CTRL_MSEL +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msgc <= '0;
      delay_r <= 32'h0;
    end else begin
      if (wr_i && addr_i == `OFC_MSGC_ADDR) begin
        msgc <= wdata_i[CW-1:0];
      end
      if (wr_i && addr_i == `OFC_DELAY_ADDR) begin
        delay_r <= wdata_i;
      end
    end
  end

  // write one clears, but a new event in the same cycle keeps the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      over_f <= 1'b0;
      under_f <= 1'b0;
    end else begin
      over_f <= set_over || (over_f && !(wr_stat && wdata_i[`OFC_STAT_OVER]));
      under_f <= set_under || (under_f && !(wr_stat && wdata_i[`OFC_STAT_UNDER]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      if (addr_i == `OFC_CTRL_ADDR) begin
        rdata_o <= {26'h0, msel, 2'h0, down, run};
      end else if (addr_i == `OFC_MSGC_ADDR) begin
        rdata_o <= 32'(msgc);
      end else if (addr_i == `OFC_DELAY_ADDR) begin
        rdata_o <= delay_r;
      end else if (addr_i == `OFC_STAT_ADDR) begin
        rdata_o <= {22'h0, st, 1'b0, out_q.valid, low_q, 2'h0, under_f, over_f};
      end else begin
        rdata_o <= 32'h0;
      end
    end
  end

  // lowest delay wins; strict compare keeps the lowest label on ties
  always_comb begin
    next_low = 2'h0;
    for (int i = 1; i < NPATH; i++) begin
      if (delay_r[i*8 +: 8] < delay_r[next_low*8 +: 8]) begin
        next_low = 2'(i);
      end
    end
  end

  // sequence layout is fixed for the whole session, so it is sampled once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= 1'b0;
      low_q <= 2'h0;
      msg_q <= 2'h0;
      msgc_q <= '0;
    end else begin
      active <= run;
      if (run && !active) begin
        low_q <= next_low;
        msg_q <= msel;
        msgc_q <= msgc;
      end
    end
  end

  // indicator octets; unused bits stay high
  always_comb begin
    ind[1] = down ? timing_phase_i : `OFC_FILL;
    ind[2] = {signal_loss_flag_n_i, remote_defect_flag_n_i,
              down | power_loss_flag_n_i, 5'h1f};
    ind[3] = `OFC_FILL;
    ind[4] = {payload_indicator_a_i[0], payload_indicator_a_i[1],
              payload_indicator_a_i[2], payload_indicator_a_i[3],
              payload_indicator_b_i[0], payload_indicator_b_i[1],
              payload_indicator_b_i[2], payload_indicator_b_i[3]};
  end

  for (genvar p = 0; p < NPATH; p++) begin : g_path
    logic [CW-1:0] pos;
    logic [CW-1:0] len;
    logic [CW-1:0] mstart;
    logic is_low;
    logic is_msg;
    ofc_octet_t oct;
    ofc_octet_t oct_r;
    logic vld_r;

    assign is_low = low_q == 2'(p);
    assign is_msg = msg_q == 2'(p);
    assign mstart = is_low ? CW'(`OFC_SEQ_LOW) : CW'(`OFC_SEQ_BASE);
    assign len = mstart + (is_msg ? msgc_q : '0);
    assign slot_w[p] = active && sync_req_i[p] && is_msg && pos >= mstart;

    ofc_seq_cnt #(.CW(CW)) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(active),
      .adv_i(sync_req_i[p]),
      .len_i(len),
      .pos_o(pos)
    );

    always_comb begin
      if (pos == '0) begin
        oct = crc_octet_i[p*8 +: 8];
      end else if (is_low && pos <= CW'(`OFC_IND_LAST)) begin
        oct = ind[pos[2:0]];
      end else if (pos < mstart) begin
        oct = `OFC_FILL;
      end else begin
        oct = msg_oct;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        vld_r <= 1'b0;
        oct_r <= 8'h00;
      end else begin
        vld_r <= sync_req_i[p] && active;
        if (sync_req_i[p]) begin
          oct_r <= oct;
        end
      end
    end

    assign ovh_valid_o[p] = vld_r;
    assign ovh_octet_o[p*8 +: 8] = oct_r;

    chk_crc_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && pos == '0 |=> vld_r && oct_r == $past(crc_octet_i[p*8 +: 8]))
      else $error("CRC octet not at position 0");
    chk_fill_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && pos == mstart - CW'(1) |=> oct_r == 8'hff)
      else $error("fill octet not all ones");
    chk_defect_layout: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && pos == CW'(2)
      |=> oct_r[4:0] == 5'h1f && oct_r[7] == $past(signal_loss_flag_n_i))
      else $error("defect octet layout wrong");
    chk_power_unused: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && down && pos == CW'(2)
      |=> oct_r[5])
      else $error("unused power loss bit not high");
    chk_phase_octet: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && pos == CW'(1)
      |=> oct_r == ($past(down) ? $past(timing_phase_i) : 8'hff))
      else $error("phase octet wrong for direction");
    chk_defect_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && pos == CW'(2)
      |=> oct_r[6] == $past(remote_defect_flag_n_i))
      else $error("remote defect bit not passed as is");
    chk_ind_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && pos == CW'(3) |=> oct_r == 8'hff)
      else $error("spare indicator octet not all ones");
    // a slot offered before the link is up must not leak an octet
    chk_valid_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !active |=> !vld_r)
      else $error("octet valid while link down");
    chk_tib_order: assert property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && is_low && pos == CW'(4)
      |=> oct_r[7] == $past(payload_indicator_a_i[0]) && oct_r[0] == $past(payload_indicator_b_i[3]))
      else $error("payload indicator order wrong");
    chk_seq_len: assert property (@(posedge clk_i) disable iff (rst_i)
      active && $stable(active) && is_low && is_msg && sync_req_i[p] && pos == msgc_q + CW'(5)
      |=> pos == '0)
      else $error("combined path sequence length wrong");
    chk_open_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      slot_w[p] && st == fr_idle |=> oct_r == 8'h7e)
      else $error("idle message slot not a flag");
    cov_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
      active && sync_req_i[p] && pos == len - CW'(1));
  end

  assign slot = |slot_w;

  // source to fifo; its ready is the back-pressure seen by the message source
  assign in_q.valid = msg_valid_i;
  assign in_q.data = {msg_last_i, msg_data_i};
  assign msg_ready_o = in_q.ready;

  ofc_fifo #(.W(9), .D(FDEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_s(in_q),
    .rd_s(out_q)
  );

  // a drained fifo mid-frame cannot be filled, so the frame is aborted
  assign out_q.ready = (st == fr_body && slot) || st == fr_drop;
  always_comb begin
    if (st == fr_body && out_q.valid) begin
      msg_oct = out_q.data[7:0];
    end else begin
      msg_oct = `OFC_FLAG;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      st <= fr_idle;
      fcnt <= 11'h0;
    end else begin
      case (st)
        fr_idle: begin
          if (slot && out_q.valid) begin
            st <= fr_body;
            fcnt <= 11'h0;
          end
        end
        fr_body: begin
          if (slot && !out_q.valid) begin
            st <= fr_drop;
          end else if (slot) begin
            fcnt <= fcnt + 11'h1;
            if (out_q.data[8]) begin
              st <= fr_idle;
            end else if (fcnt == `OFC_FRAME_MAX - 11'h1) begin
              st <= fr_drop;
            end
          end
        end
        fr_drop: begin
          if (out_q.valid && out_q.data[8]) begin
            st <= fr_idle;
          end
        end
        default: begin
          st <= fr_idle;
        end
      endcase
    end
  end

  assign set_over = st == fr_body && slot && out_q.valid && !out_q.data[8]
    && fcnt == `OFC_FRAME_MAX - 11'h1;
  assign set_under = st == fr_body && slot && !out_q.valid;

  chk_msg_path: assert property (@(posedge clk_i) disable iff (rst_i)
    st == fr_body && out_q.ready |-> slot_w[msg_q])
    else $error("message octet outside message path");
  chk_frame_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    st == fr_body |-> fcnt < 11'h404)
    else $error("message frame beyond body limit");
  chk_over_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    set_over |=> over_f && st == fr_drop)
    else $error("oversize frame not rejected");
  chk_under_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    set_under |=> under_f && st == fr_drop)
    else $error("underrun not flagged");
  // the layout is fixed for the session even if the delays are rewritten
  chk_low_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    active && $past(active) |-> $stable(low_q) && $stable(msg_q) && $stable(msgc_q))
    else $error("path layout changed while running");

  cov_frame_done: cover property (@(posedge clk_i) disable iff (rst_i)
    st == fr_body ##1 st == fr_idle);
  cov_oversize: cover property (@(posedge clk_i) disable iff (rst_i) set_over);
  cov_underrun: cover property (@(posedge clk_i) disable iff (rst_i) set_under);
  cov_fifo_full: cover property (@(posedge clk_i) disable iff (rst_i)
    msg_valid_i && !msg_ready_o);
endmodule : ofc_framer
`default_nettype wire

// >>> tb/ofc_peer_model.sv
// far-end model: sync octet slots and CRC octets per latency path
`timescale 1ns/1ns
`default_nettype none
module ofc_peer_model #(
  parameter int NPATH = 4
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic en_i, // slots allowed
  input wire logic slow_i, // sparse random slots
  output logic [NPATH-1:0] sync_req_o, // slot per path
  output logic [NPATH*8-1:0] crc_octet_o // CRC octet per path
);
  initial begin
    sync_req_o = '0;
    crc_octet_o = '0;
  end
  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      sync_req_o <= '0;
      // outside slots the CRC lines never keep a stale value
      crc_octet_o <= ~crc_octet_o;
    end else begin
      sync_req_o <= slow_i ? NPATH'($urandom) : '1;
      crc_octet_o <= (NPATH*8)'({$urandom, $urandom});
    end
  end
endmodule : ofc_peer_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the overhead channel framer
`timescale 1ns/1ns
`default_nettype none
`include "ofc_regs.svh"
module testbench;
  import ofc_pkg::*;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, pen = 0, slow = 0;
  logic [7:0] addr_i = '0, timing_phase_i = '0, msg_data_i = '0;
  logic [31:0] wdata_i = '0, dly;
  logic signal_loss_flag_n_i = 1, remote_defect_flag_n_i = 1, power_loss_flag_n_i = 1;
  logic [3:0] payload_indicator_a_i = '0, payload_indicator_b_i = '0;
  logic msg_valid_i = 0, msg_last_i = 0, msg_ready_o, down;
  logic [31:0] rdata_o;
  logic [3:0] sync_req_i, ovh_valid_o, exp_v = '0;
  logic [31:0] crc_octet_i, ovh_octet_o;
  ofc_octet_t exp_o [4];
  ofc_octet_t msgq [$];
  int pos [4];
  int errors = 0, comparisons = 0, cyc = 0, lowp, msel, msgc;

  always #10 clk_i = ~clk_i;

  ofc_framer #(.NPATH(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sync_req_i(sync_req_i), .crc_octet_i(crc_octet_i), .ovh_valid_o(ovh_valid_o),
    .ovh_octet_o(ovh_octet_o), .timing_phase_i(timing_phase_i),
    .signal_loss_flag_n_i(signal_loss_flag_n_i),
    .remote_defect_flag_n_i(remote_defect_flag_n_i),
    .power_loss_flag_n_i(power_loss_flag_n_i),
    .payload_indicator_a_i(payload_indicator_a_i),
    .payload_indicator_b_i(payload_indicator_b_i), .msg_valid_i(msg_valid_i),
    .msg_ready_o(msg_ready_o), .msg_data_i(msg_data_i), .msg_last_i(msg_last_i));

  ofc_peer_model #(.NPATH(4)) u_peer (.clk_i(clk_i), .rst_i(rst_i), .en_i(pen),
    .slow_i(slow), .sync_req_o(sync_req_i), .crc_octet_o(crc_octet_i));

  task automatic end_of_test;
    $display("checks %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk1(string n, logic e, logic s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, s);
    end
  endtask : chk1

  task automatic chk8(int p, ofc_octet_t e, ofc_octet_t s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] octet path %0d expected %h seen %h", p, e, s);
    end
  endtask : chk8

  task automatic chk32(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk32

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk32(n, e, rdata_o);
  endtask : rd

  // keeps valid high and offers a new octet after every accepted one
  task automatic feed(int n, int keep, logic lst);
    msg_valid_i <= 1;
    for (int i = 0; i < n; i++) begin
      msg_data_i <= 8'($urandom);
      msg_last_i <= lst && i == n - 1;
      #1 if (i < keep) msgq.push_back(msg_data_i);
      do @(posedge clk_i); while (msg_ready_o !== 1'b1);
    end
    msg_valid_i <= 0;
  endtask : feed

  task automatic go(int c);
    wr(`OFC_DELAY_ADDR, 32'h0);
    wr(`OFC_MSGC_ADDR, c);
    wr(`OFC_CTRL_ADDR, 32'h1);
    repeat (2) @(posedge clk_i);
    slow <= 0;
    pen <= 1;
  endtask : go

  task automatic reset_dut;
    @(posedge clk_i);
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    msgq.delete();
    msgq.push_back(8'h7e);
    down = 0;
    msel = 0;
    lowp = 0;
  endtask : reset_dut

  function automatic int seqlen(int p);
    return (p == lowp ? 6 : 2) + (p == msel ? msgc : 0);
  endfunction : seqlen

  function automatic ofc_octet_t exp_oct(int p, int k);
    if (k == 0) return crc_octet_i[p*8+:8];
    if (p == lowp && k < 5) begin
      case (k)
        1: return down ? timing_phase_i : 8'hff;
        2: return {signal_loss_flag_n_i, remote_defect_flag_n_i,
                   power_loss_flag_n_i | down, 5'h1f};
        3: return 8'hff;
        default: return {payload_indicator_a_i[0], payload_indicator_a_i[1],
                         payload_indicator_a_i[2], payload_indicator_a_i[3],
                         payload_indicator_b_i[0], payload_indicator_b_i[1],
                         payload_indicator_b_i[2], payload_indicator_b_i[3]};
      endcase
    end
    if (k == (p == lowp ? 5 : 1)) return 8'hff;
    // idle message slots carry the flag octet
    return msgq.size() > 0 ? msgq.pop_front() : 8'h7e;
  endfunction : exp_oct

  // outputs read at the edge still show the previous cycle's registered values
  always @(posedge clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (!rst_i && exp_v[p]) chk8(p, exp_o[p], ovh_octet_o[p*8+:8]);
      if (!rst_i) chk1("ovh valid", exp_v[p], ovh_valid_o[p]);
      exp_v[p] = 0;
      if (rst_i) pos[p] = 0;
      else if (sync_req_i[p]) begin
        exp_v[p] = 1;
        exp_o[p] = exp_oct(p, pos[p]);
        pos[p] = (pos[p] + 1 == seqlen(p)) ? 0 : pos[p] + 1;
      end
    end
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'he5ed));
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(`OFC_CTRL_ADDR, `OFC_CTRL_RESET, "ctrl reset");
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0, "unmapped");
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_i);
      rst_i <= 1;
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      msgq.delete();
      down = r[0];
      msel = r;
      msgc = 1 + $urandom % 3;
      dly = $urandom & 32'h0303_0303;
      if (r == 1) dly = 32'h0505_0505;
      if (r == 3) dly = 32'h0105_0505;
      lowp = 0;
      for (int p = 1; p < 4; p++) if (dly[p*8+:8] < dly[lowp*8+:8]) lowp = p;
      msgq.push_back(8'h7e);
      for (int i = 0; i < 16; i++) begin
        @(posedge clk_i);
        msg_valid_i <= 1;
        msg_data_i <= $urandom;
        msg_last_i <= (i == 15);
        #1 msgq.push_back(msg_data_i);
        do @(posedge clk_i); while (msg_ready_o !== 1'b1);
        msg_valid_i <= 0;
      end
      msgq.push_back(8'h7e);
      // a seventeenth octet must wait while the fifo is full
      msg_valid_i <= 1;
      msg_last_i <= 0;
      repeat (3) @(posedge clk_i);
      #1 chk1("msg ready full", 1'b0, msg_ready_o);
      @(posedge clk_i);
      msg_valid_i <= 0;
      wr(`OFC_DELAY_ADDR, dly);
      wr(`OFC_MSGC_ADDR, msgc);
      wr(`OFC_CTRL_ADDR, {26'h0, 2'(msel), 2'b00, down, 1'b1});
      repeat (2) @(posedge clk_i);
      slow <= ~r[0];
      pen <= 1;
      repeat (300) begin
        @(posedge clk_i);
        timing_phase_i <= $urandom;
        {signal_loss_flag_n_i, remote_defect_flag_n_i, power_loss_flag_n_i} <= $urandom;
        payload_indicator_a_i <= $urandom;
        payload_indicator_b_i <= $urandom;
      end
      pen <= 0;
      repeat (2) @(posedge clk_i);
      chk32("msg drained", 32'h0, 32'(msgq.size()));
      rd(`OFC_STAT_ADDR, 32'(lowp) << 4, "status");
    end
    // a frame cut short by an empty fifo: flag, underrun, rest dropped
    reset_dut();
    msgc = 2;
    feed(3, 3, 1'b0);
    go(2);
    repeat (40) @(posedge clk_i);
    pen <= 0;
    repeat (2) @(posedge clk_i);
    chk32("underrun drained", 32'h0, 32'(msgq.size()));
    rd(`OFC_STAT_ADDR, 32'h0000_0202, "underrun status");
    wr(`OFC_STAT_ADDR, 32'h2);
    rd(`OFC_STAT_ADDR, 32'h0000_0200, "underrun cleared");
    // a body past the largest legal frame is cut and its tail dropped
    reset_dut();
    msgc = 1100;
    fork
      feed(1030, 1028, 1'b1);
      go(1100);
    join
    repeat (20) @(posedge clk_i);
    pen <= 0;
    repeat (2) @(posedge clk_i);
    chk32("oversize drained", 32'h0, 32'(msgq.size()));
    rd(`OFC_STAT_ADDR, 32'h0000_0001, "oversize status");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
